//--- vector_defs.svh
// constants for the vector slot map and interrupt entry stacking
`ifndef VECTOR_DEFS_SVH
`define VECTOR_DEFS_SVH

// ****************************************************************
// slot map
// ****************************************************************
`define VEC_BASE_ADDR     16'hFFCC
`define VEC_TOP_ADDR      16'hFFFF
`define VEC_RESET_ADDR    16'hFFFE
`define VEC_NUM_SLOTS     26
`define VEC_SLOT_W        5
`define VEC_SRC_W         32

// ****************************************************************
// source bit positions in the request vector
// ****************************************************************
`define SRC_TIMER_A_CH5   0
`define SRC_TIMER_A_CH4   1
`define SRC_CONVERTER     2
`define SRC_KEYBOARD      3
`define SRC_SCI_TX        4
`define SRC_SCI_RX        5
`define SRC_SCI_ERR       6
`define SRC_CAN_TX        7
`define SRC_CAN_RX        8
`define SRC_CAN_ERR       9
`define SRC_CAN_WAKE      10
`define SRC_SPI_TX        11
`define SRC_SPI_RX        12
`define SRC_TIMER_B_OVF   13
`define SRC_TIMER_B_CH1   14
`define SRC_TIMER_B_CH0   15
`define SRC_TIMER_A_OVF   16
`define SRC_TIMER_A_CH3   17
`define SRC_TIMER_A_CH2   18
`define SRC_TIMER_A_CH1   19
`define SRC_TIMER_A_CH0   20
`define SRC_PERIODIC      21
`define SRC_LINK_CTRL     22
`define SRC_CLOCK_SYNTH   23
`define SRC_EXT_PIN       24
`define SRC_SW_INSTR      25
`define SRC_RESET         26

// ****************************************************************
// stacking
// ****************************************************************
`define STACK_RESET_VAL   16'h00FF
`define STACK_ENTRY_BYTES 3'h5
`define NO_SLOT           5'h1F

`endif

//--- vector_pkg.sv
// types shared by the vector and stacking logic
package vector_pkg;
    timeunit 1ns;
    timeprecision 1ps;

    // layout chosen at build time
    typedef enum logic [0:0] {
        LAYOUT_FULL    = 1'b0,
        LAYOUT_REDUCED = 1'b1
    } layout_t;

    // a granted interrupt as seen by the cpu
    typedef struct packed {
        logic        valid;
        logic [4:0]  slot;
        logic [15:0] vecAddr;
    } grant_t;

    // cpu register image pushed on entry
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0]  x;
        logic [7:0]  acc;
        logic [7:0]  ccr;
    } cpu_regs_t;

    // one byte write toward stack ram
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  data;
    } stack_wr_t;

endpackage

//--- slot_map.sv
// maps raw source requests onto vector slots for one layout
`include "vector_defs.svh"

module slot_map
    import vector_pkg::*;
#(
    parameter layout_t LAYOUT = LAYOUT_FULL
) (
    input  wire logic [`VEC_SRC_W-1:0] srcReq,
    output logic      [`VEC_NUM_SLOTS-1:0] slotReq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // slot routing
    // ****************************************************************
    // slot 0 is 0xFFCC, slot 25 is 0xFFFE (reset)
    always_comb begin
        slotReq = '0;
        if (LAYOUT == LAYOUT_FULL) begin
            slotReq[0]  = srcReq[`SRC_TIMER_A_CH5]; // see RULE4
            slotReq[1]  = srcReq[`SRC_TIMER_A_CH4]; // see RULE4
            slotReq[2]  = srcReq[`SRC_CONVERTER];   // see RULE4
            slotReq[4]  = srcReq[`SRC_SCI_TX];      // see RULE5
            slotReq[5]  = srcReq[`SRC_SCI_RX];      // see RULE5
            slotReq[6]  = srcReq[`SRC_SCI_ERR];     // see RULE5
            slotReq[7]  = srcReq[`SRC_CAN_TX];      // see RULE6
            slotReq[8]  = srcReq[`SRC_CAN_RX];      // see RULE6
            slotReq[9]  = srcReq[`SRC_CAN_ERR];     // see RULE6
            slotReq[10] = srcReq[`SRC_CAN_WAKE];    // see RULE6
            slotReq[11] = srcReq[`SRC_SPI_TX];      // see RULE7
            slotReq[12] = srcReq[`SRC_SPI_RX];      // see RULE7
            slotReq[13] = srcReq[`SRC_TIMER_B_OVF]; // see RULE8
            slotReq[14] = srcReq[`SRC_TIMER_B_CH1]; // see RULE8
            slotReq[15] = srcReq[`SRC_TIMER_B_CH0]; // see RULE8
            slotReq[16] = srcReq[`SRC_TIMER_A_OVF]; // see RULE9
            slotReq[17] = srcReq[`SRC_TIMER_A_CH3]; // see RULE9
            slotReq[18] = srcReq[`SRC_TIMER_A_CH2]; // see RULE9
            slotReq[19] = srcReq[`SRC_TIMER_A_CH1]; // see RULE9
            slotReq[20] = srcReq[`SRC_TIMER_A_CH0]; // see RULE9
            slotReq[21] = srcReq[`SRC_PERIODIC];    // see RULE9
        end else begin
            // low slots other than keyboard slot 3 stay reserved; can sources have no home here
            slotReq[7]  = srcReq[`SRC_PERIODIC];    // see RULE10
            slotReq[8]  = srcReq[`SRC_LINK_CTRL];   // see RULE10
            slotReq[9]  = srcReq[`SRC_CONVERTER];   // see RULE10
            slotReq[10] = srcReq[`SRC_SCI_TX];      // see RULE5 see RULE10
            slotReq[11] = srcReq[`SRC_SCI_RX];      // see RULE5 see RULE10
            slotReq[12] = srcReq[`SRC_SCI_ERR];     // see RULE5 see RULE10
            slotReq[13] = srcReq[`SRC_SPI_TX];      // see RULE10
            slotReq[14] = srcReq[`SRC_SPI_RX];      // see RULE10
            slotReq[15] = srcReq[`SRC_TIMER_A_OVF]; // see RULE10
            slotReq[16] = srcReq[`SRC_TIMER_A_CH5]; // see RULE10
            slotReq[17] = srcReq[`SRC_TIMER_A_CH4]; // see RULE10
            slotReq[18] = srcReq[`SRC_TIMER_A_CH3]; // see RULE10
            slotReq[19] = srcReq[`SRC_TIMER_A_CH2]; // see RULE10
            slotReq[20] = srcReq[`SRC_TIMER_A_CH1]; // see RULE10
            slotReq[21] = srcReq[`SRC_TIMER_A_CH0]; // see RULE10
        end
        slotReq[3]  = srcReq[`SRC_KEYBOARD];       // see RULE4
        slotReq[22] = srcReq[`SRC_CLOCK_SYNTH];    // see RULE11
        slotReq[23] = srcReq[`SRC_EXT_PIN];        // see RULE11
        slotReq[24] = srcReq[`SRC_SW_INSTR];       // see RULE11
        slotReq[25] = srcReq[`SRC_RESET];          // see RULE11
    end

endmodule // slot_map

//--- slot_priority.sv
// picks the highest pending slot and forms its vector address
`include "vector_defs.svh"

module slot_priority
    import vector_pkg::*;
(
    input  wire logic [`VEC_NUM_SLOTS-1:0] slotReq,
    output grant_t                         grant
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // priority search
    // ****************************************************************
    // later, higher slots overwrite lower ones so the top one wins
    always_comb begin
        grant = '0;
        for (int i = 0; i < `VEC_NUM_SLOTS; i++) begin
            if (slotReq[i]) begin
                grant.valid = 1'b1;                                    // see RULE2
                grant.slot  = 5'(i);                                   // see RULE2
                grant.vecAddr = `VEC_BASE_ADDR + {10'h000, 5'(i), 1'b0}; // see RULE1
            end
        end
    end

endmodule // slot_priority

//--- vector_table_priority_logic.sv
// vector slot priority, vector fetch and interrupt entry stacking
// What this block does
// RULE1 - slots from 0xFFCC to 0xFFFF, two bytes each, high byte even
// RULE2 - higher slot address means higher priority, reset slot highest
// RULE3 - variant parameter chooses between two slot layouts
// RULE4 - full layout: timer_a ch5, ch4, converter lowest; keyboard next in both
// RULE5 - serial tx, rx, error take three slots; moved higher in reduced layout
// RULE6 - full layout: can tx, rx, error, wakeup in four rising slots
// RULE7 - full layout: synchronous serial tx then rx one slot higher
// RULE8 - full layout: timer_b overflow, ch1, ch0 in rising slots
// RULE9 - full layout: timer_a overflow, ch3 to ch0, then periodic_timer
// RULE10 - reduced layout: periodic_timer, link, converter, serial, timer_a upward
// RULE11 - top four slots: clock synth, external pin, software_interrupt_instr, reset
// RULE12 - five bytes of cpu state pushed before servicing an interrupt
// RULE13 - the high index register is not pushed on interrupt entry
// RULE14 - 16-bit stack pointer decrements on push, increments on pull
// RULE15 - stack pointer resets to 0x00FF; reload instruction restores it
// RULE16 - software should program every vector slot
`include "vector_defs.svh"

module vector_table_priority_logic
    import vector_pkg::*;
#(
    parameter layout_t LAYOUT = LAYOUT_FULL
) (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic [`VEC_SRC_W-1:0] srcReq,
    input  wire logic                  intEnable,
    input  wire logic                  entryStart,
    input  wire cpu_regs_t             cpuRegs,
    input  wire logic                  pullReq,
    input  wire logic                  spReload,
    input  wire logic                  spLoad,
    input  wire logic [15:0]           spLoadVal,
    input  wire logic [7:0]            vecRdData,
    output logic                       intPending,
    output logic [4:0]                 pendSlot,
    output stack_wr_t                  stackWr,
    output logic [15:0]                vecRdAddr,
    output logic                       vecRdEn,
    output logic [15:0]                vectorPc,
    output logic                       entryDone,
    output logic                       entryBusy,
    output logic [15:0]                stackPtr
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // slot mapping and priority
    // ****************************************************************
    logic [`VEC_NUM_SLOTS-1:0] slotReq;
    grant_t                    grant;

    // layout picked at build time, never at run time
    slot_map #(
        .LAYOUT (LAYOUT)                        // see RULE3
    ) u_map (
        .srcReq  (srcReq),
        .slotReq (slotReq)
    );

    slot_priority u_prio (
        .slotReq (slotReq),
        .grant   (grant)
    );

    // ****************************************************************
    // entry sequencer
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_PUSH   = 3'b001,
        ST_VEC_HI = 3'b010,
        ST_VEC_LO = 3'b011,
        ST_DONE   = 3'b100
    } entry_state_t;

    entry_state_t stateFf;
    entry_state_t nxt_stateFf;
    logic [2:0]   byteCntFf;
    logic [2:0]   nxt_byteCntFf;
    logic [15:0]  spFf;
    logic [15:0]  nxt_spFf;
    cpu_regs_t    regsFf;
    cpu_regs_t    nxt_regsFf;
    logic [15:0]  vecAddrFf;
    logic [15:0]  nxt_vecAddrFf;
    logic [15:0]  pcFf;
    logic [15:0]  nxt_pcFf;
    stack_wr_t    wrFf;
    stack_wr_t    nxt_wrFf;
    logic [7:0]   pushByte;

    // push order: pc low, pc high, x, accumulator, ccr; no h register
    always_comb begin
        unique case (byteCntFf)
            3'h0:    pushByte = regsFf.pc[7:0];
            3'h1:    pushByte = regsFf.pc[15:8];
            3'h2:    pushByte = regsFf.x;     // see RULE13
            3'h3:    pushByte = regsFf.acc;
            3'h4:    pushByte = regsFf.ccr;
            default: pushByte = 8'h00;
        endcase
    end

    // next-state logic for sequencer and stack pointer
    always_comb begin
        nxt_stateFf   = stateFf;
        nxt_byteCntFf = byteCntFf;
        nxt_spFf      = spFf;
        nxt_regsFf    = regsFf;
        nxt_vecAddrFf = vecAddrFf;
        nxt_pcFf      = pcFf;
        nxt_wrFf      = '0;
        unique case (stateFf)
            ST_IDLE: begin
                // priority is frozen at entry so a late request cannot swap vectors
                if (entryStart && grant.valid && intEnable) begin
                    nxt_stateFf   = ST_PUSH;
                    nxt_byteCntFf = 3'h0;
                    nxt_regsFf    = cpuRegs;
                    nxt_vecAddrFf = grant.vecAddr;     // see RULE2
                end else if (spReload) begin
                    nxt_spFf = `STACK_RESET_VAL;        // see RULE15
                end else if (spLoad) begin
                    nxt_spFf = spLoadVal;
                end else if (pullReq) begin
                    nxt_spFf = spFf + 16'h0001;         // see RULE14
                end
            end
            ST_PUSH: begin
                nxt_wrFf.we   = 1'b1;
                nxt_wrFf.addr = spFf;
                nxt_wrFf.data = pushByte;
                nxt_spFf      = spFf - 16'h0001;        // see RULE14
                nxt_byteCntFf = byteCntFf + 3'h1;
                if (byteCntFf == `STACK_ENTRY_BYTES - 3'h1) begin
                    nxt_stateFf = ST_VEC_HI;            // see RULE12
                end
            end
            ST_VEC_HI: begin
                // high byte at the even address, returned one cycle later
                nxt_stateFf = ST_VEC_LO;                // see RULE1
            end
            ST_VEC_LO: begin
                nxt_pcFf[15:8] = vecRdData;             // see RULE1
                nxt_stateFf    = ST_DONE;
            end
            ST_DONE: begin
                nxt_pcFf[7:0] = vecRdData;              // see RULE1
                nxt_stateFf   = ST_IDLE;
            end
            default: begin
                nxt_stateFf = ST_IDLE;
            end
        endcase
    end

    // registers of the sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stateFf   <= ST_IDLE;
            byteCntFf <= 3'h0;
            spFf      <= `STACK_RESET_VAL;              // see RULE15
            regsFf    <= '0;
            vecAddrFf <= `VEC_RESET_ADDR;
            pcFf      <= 16'h0000;
            wrFf      <= '0;
        end else begin
            stateFf   <= nxt_stateFf;
            byteCntFf <= nxt_byteCntFf;
            spFf      <= nxt_spFf;
            regsFf    <= nxt_regsFf;
            vecAddrFf <= nxt_vecAddrFf;
            pcFf      <= nxt_pcFf;
            wrFf      <= nxt_wrFf;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // vector fetch: even byte then odd byte of the frozen slot
    assign vecRdEn    = (stateFf == ST_VEC_HI) || (stateFf == ST_VEC_LO);
    assign vecRdAddr  = (stateFf == ST_VEC_LO) ? (vecAddrFf | 16'h0001) : vecAddrFf;
    assign intPending = grant.valid && intEnable;
    assign pendSlot   = grant.valid ? grant.slot : `NO_SLOT;
    assign stackWr    = wrFf;
    assign vectorPc   = pcFf;
    assign entryDone  = (stateFf == ST_DONE);
    assign entryBusy  = (stateFf != ST_IDLE);
    assign stackPtr   = spFf;

endmodule // vector_table_priority_logic

//--- vec_rom_model.sv
// vector store seen by the cpu core: answers one byte a cycle after each read
module vec_rom_model (
    input  wire logic        sys_clk,
    input  wire logic        vecRdEn,
    input  wire logic [15:0] vecRdAddr,
    output logic      [7:0]  vecRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] dataQ = 8'h00;
    assign vecRdData = dataQ;
    // every slot holds a defined byte; idle cycles toggle so stale data never looks valid
    always @(posedge sys_clk) begin
        if (vecRdEn)
            dataQ <= vecRdAddr[7:0] ^ 8'h5A;
        else
            dataQ <= ~dataQ;
    end
endmodule // vec_rom_model

//--- vector_table_priority_logic_properties.sv
// temporal checks on the vector priority and entry stacking ports
`include "vector_defs.svh"
module vector_table_priority_logic_properties
    import vector_pkg::*;
#(parameter layout_t LAYOUT = LAYOUT_FULL) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [31:0] srcReq,
    input wire logic        intEnable,
    input wire logic        entryStart,
    input wire cpu_regs_t   cpuRegs,
    input wire logic        pullReq,
    input wire logic        spReload,
    input wire logic        spLoad,
    input wire logic [15:0] spLoadVal,
    input wire logic [7:0]  vecRdData,
    input wire logic        intPending,
    input wire logic [4:0]  pendSlot,
    input wire stack_wr_t   stackWr,
    input wire logic [15:0] vecRdAddr,
    input wire logic        vecRdEn,
    input wire logic [15:0] vectorPc,
    input wire logic        entryDone,
    input wire logic        entryBusy,
    input wire logic [15:0] stackPtr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ****************************************************************
    // entry steps
    // ****************************************************************
    sequence takeS;
        !entryBusy && entryStart && intPending;
    endsequence
    sequence pushS;
        !stackWr.we ##1 stackWr.we [*5] ##1 !stackWr.we;
    endsequence
    sequence fetchS;
        vecRdEn && !vecRdAddr[0] ##1 vecRdEn && vecRdAddr[0] ##1 entryDone;
    endsequence
    five_push_a: assert property (takeS |=> pushS)
        else $error("entry push count wrong");
    fetch_order_a: assert property (takeS |-> ##6 fetchS)
        else $error("vector fetch order wrong");
    last_byte_a: assert property (takeS |-> ##6 stackWr.data == $past(cpuRegs.ccr, 6))
        else $error("fifth pushed byte is not ccr");
    push_down_a: assert property (stackWr.we && $past(stackWr.we)
        |-> stackWr.addr == $past(stackWr.addr) - 16'h1) else $error("push address not falling");
    sp_entry_a: assert property (takeS |-> ##8 stackPtr == $past(stackPtr, 8) - 16'h5)
        else $error("stack pointer not down by five");
    sp_pull_a: assert property (!entryBusy && !entryStart && pullReq && !spLoad && !spReload
        |=> stackPtr == $past(stackPtr) + 16'h1) else $error("pull did not raise pointer");
    sp_reload_a: assert property (!entryBusy && !entryStart && spReload
        |=> stackPtr == 16'h00FF) else $error("reload value wrong");
    vec_range_a: assert property (vecRdEn |-> vecRdAddr >= 16'hFFCC)
        else $error("vector read below slot area");
    reset_top_a: assert property (srcReq[`SRC_RESET] && intEnable
        |-> intPending && pendSlot == 5'h19) else $error("reset source not on top");
    lowest_slot_a: assert property (srcReq == 32'h1
        |-> pendSlot == (LAYOUT == LAYOUT_FULL ? 5'h00 : 5'h10)) else $error("lowest slot wrong");
    no_request_a: assert property (!intEnable || srcReq == 32'h0 |-> !intPending)
        else $error("pending without request");
endmodule // vector_table_priority_logic_properties
bind vector_table_priority_logic vector_table_priority_logic_properties #(.LAYOUT(LAYOUT)) chk_u (
    .sys_clk(sys_clk), .nrst(nrst), .srcReq(srcReq), .intEnable(intEnable),
    .entryStart(entryStart), .cpuRegs(cpuRegs), .pullReq(pullReq), .spReload(spReload),
    .spLoad(spLoad), .spLoadVal(spLoadVal), .vecRdData(vecRdData), .intPending(intPending),
    .pendSlot(pendSlot), .stackWr(stackWr), .vecRdAddr(vecRdAddr), .vecRdEn(vecRdEn),
    .vectorPc(vectorPc), .entryDone(entryDone), .entryBusy(entryBusy), .stackPtr(stackPtr));

//--- vector_table_priority_logic_tb_top.sv
// self-checking bench for slot priority, vector fetch and entry stacking
`include "vector_defs.svh"
module vector_table_priority_logic_tb_top import vector_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, nrst = 1'b0, intEnable = 1'b0, entryStart = 1'b0;
    logic pullReq = 1'b0, spReload = 1'b0, spLoad = 1'b0, doneD = 1'b0;
    logic [31:0] srcReq = 32'h0;
    logic [15:0] spLoadVal = 16'h0, spExp = 16'h00FF;
    cpu_regs_t   cpuRegs = '0;
    logic [7:0]  vecRdData;
    logic        intPending, vecRdEn, entryDone, entryBusy;
    logic [4:0]  pendSlot, redSlot;
    logic [15:0] vecRdAddr, vectorPc, stackPtr;
    stack_wr_t   stackWr;
    logic [23:0] stkQ[$];
    logic [15:0] pcQ[$];
    int num_errors = 0, n_compared = 0;
    integer seed = 32'h0EEDCFE2;
    always #5 sys_clk = ~sys_clk;
    vector_table_priority_logic #(.LAYOUT(LAYOUT_FULL)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
        .srcReq(srcReq), .intEnable(intEnable), .entryStart(entryStart), .cpuRegs(cpuRegs),
        .pullReq(pullReq), .spReload(spReload), .spLoad(spLoad), .spLoadVal(spLoadVal),
        .vecRdData(vecRdData), .intPending(intPending), .pendSlot(pendSlot), .stackWr(stackWr),
        .vecRdAddr(vecRdAddr), .vecRdEn(vecRdEn), .vectorPc(vectorPc), .entryDone(entryDone),
        .entryBusy(entryBusy), .stackPtr(stackPtr));
    // second layout only judged on its slot choice
    vector_table_priority_logic #(.LAYOUT(LAYOUT_REDUCED)) redDut (.sys_clk(sys_clk),
        .nrst(nrst), .srcReq(srcReq), .intEnable(intEnable), .entryStart(entryStart),
        .cpuRegs(cpuRegs), .pullReq(pullReq), .spReload(spReload), .spLoad(spLoad),
        .spLoadVal(spLoadVal), .vecRdData(vecRdData), .intPending(), .pendSlot(redSlot),
        .stackWr(), .vecRdAddr(), .vecRdEn(), .vectorPc(), .entryDone(), .entryBusy(),
        .stackPtr());
    vec_rom_model rom_u (.sys_clk(sys_clk), .vecRdEn(vecRdEn), .vecRdAddr(vecRdAddr),
        .vecRdData(vecRdData));
    // ****************************************************************
    // compare and report
    // ****************************************************************
    task automatic fail(string m);
        num_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chkSlot(logic [4:0] g, logic [4:0] e, string m);
        n_compared++;
        if (g !== e) fail(m);
    endtask
    task automatic chkWord(logic [15:0] g, logic [15:0] e, string m);
        n_compared++;
        if (g !== e) fail(m);
    endtask
    task automatic chkStack(logic [23:0] g, logic [23:0] e);
        n_compared++;
        if (g !== e) fail("pushed byte");
    endtask
    task automatic results();
        // notes still queued mean the design never produced them
        if (stkQ.size() != 0 || pcQ.size() != 0)
            fail("expected result never seen");
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // expected slot of one source; 0x1F when the layout leaves it out
    function automatic logic [4:0] slotOf(bit red, int s);
        if (s >= 23) return 5'(s - 1);
        if (!red) return (s == 22) ? `NO_SLOT : 5'(s);
        case (s)
            0, 1: return 5'(s + 16);
            2: return 5'h09;
            3: return 5'h03;
            4, 5, 6: return 5'(s + 6);
            11, 12: return 5'(s + 2);
            16: return 5'h0F;
            17, 18, 19, 20: return 5'(s + 1);
            21: return 5'h07;
            22: return 5'h08;
            default: return `NO_SLOT;
        endcase
    endfunction
    function automatic logic [4:0] maxSlot(bit red, logic [31:0] v);
        logic [4:0] m, s;
        m = `NO_SLOT;
        for (int b = 0; b < 27; b++) begin
            s = slotOf(red, b);
            if (v[b] && s != `NO_SLOT && (m == `NO_SLOT || s > m)) m = s;
        end
        return m;
    endfunction
    // ****************************************************************
    // result watcher: pushes and fetched vectors against the notes
    // ****************************************************************
    always @(posedge sys_clk) begin
        doneD <= entryDone;
        if (stackWr.we === 1'b1) begin
            if (stkQ.size() == 0) fail("unexpected push");
            else chkStack({stackWr.addr, stackWr.data}, stkQ.pop_front());
        end
        if (doneD) begin
            if (pcQ.size() == 0) fail("unexpected vector");
            else chkWord(vectorPc, pcQ.pop_front(), "vector");
        end
    end
    // single sources then random mixes, both layouts
    task automatic scan();
        logic [31:0] v;
        logic        pe;
        for (int i = 0; i < 80; i++) begin
            v = (i < 27) ? 32'h1 << i : $random(seed) & (i[0] ? 32'h07FFFFFF : 32'h003FFFFF);
            @(posedge sys_clk);
            srcReq <= v;
            intEnable <= 1'($random(seed));
            @(posedge sys_clk);
            chkSlot(pendSlot, maxSlot(0, v), "full slot");
            chkSlot(redSlot, maxSlot(1, v), "reduced slot");
            pe = intEnable && (maxSlot(0, v) != `NO_SLOT);
            chkSlot(5'(intPending), 5'(pe), "pending");
        end
        $display("test scan done");
    endtask
    // one entry, refused when ok is low; when taken, a pull is issued while busy and must be ignored
    task automatic doEntry(int s, bit ok);
        logic [63:0] rv;
        logic [15:0] va;
        cpu_regs_t   r;
        int          n;
        rv = {$random(seed), $random(seed)};
        r = rv[39:0];
        va = 16'hFFCC + {10'h0, slotOf(0, s), 1'b0};
        if (ok) begin
            stkQ.push_back({spExp, r.pc[7:0]});
            stkQ.push_back({spExp - 16'h1, r.pc[15:8]});
            stkQ.push_back({spExp - 16'h2, r.x});
            stkQ.push_back({spExp - 16'h3, r.acc});
            stkQ.push_back({spExp - 16'h4, r.ccr});
            pcQ.push_back({va[7:0] ^ 8'h5A, (va[7:0] + 8'h1) ^ 8'h5A});
        end
        @(posedge sys_clk);
        srcReq <= 32'h1 << s;
        intEnable <= ok;
        cpuRegs <= r;
        entryStart <= 1'b1;
        @(posedge sys_clk);
        entryStart <= 1'b0;
        pullReq <= ok;
        n = 0;
        do begin
            @(posedge sys_clk);
            pullReq <= 1'b0;
            n++;
        end while (entryBusy !== 1'b0 && n < 30);
        if (n >= 30) fail("entry hang");
        if (!ok) repeat (10) @(posedge sys_clk);
        if (ok) spExp = spExp - 16'h5;
        chkWord(stackPtr, spExp, "sp after entry");
    endtask
    task automatic spOp(bit pl, bit ld, bit rl, logic [15:0] v, logic [15:0] e);
        @(posedge sys_clk);
        {pullReq, spLoad, spReload, spLoadVal} <= {pl, ld, rl, v};
        @(posedge sys_clk);
        {pullReq, spLoad, spReload} <= 3'h0;
        @(posedge sys_clk);
        spExp = e;
        chkWord(stackPtr, e, "sp op");
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        chkWord(stackPtr, 16'h00FF, "reset sp");
        scan();
        for (int s = 0; s < 27; s++)
            if (s != 22) doEntry(s, 1'b1);
        doEntry(3, 1'b0);
        $display("test entry done");
        spOp(1'b0, 1'b1, 1'b0, 16'h0480, 16'h0480);
        doEntry(26, 1'b1);
        spOp(1'b1, 1'b0, 1'b0, 16'h0, spExp + 16'h1);
        spOp(1'b1, 1'b1, 1'b1, 16'h1234, 16'h00FF);
        $display("test stack done");
        results();
    end
    // watchdog at about ten times the few hundred cycles the tests need
    initial begin
        #50000;
        fail("timeout");
        results();
    end
endmodule // vector_table_priority_logic_tb_top
